/* File: response_host.sv */
// Host model sending responses on the far side of the block
`timescale 1ns/1ns
`default_nettype none
module response_host
	import supply_fault_pkg::*;
(
	input wire logic send_in,
	input wire logic allow_in,
	input wire logic supply_in,
	input wire logic reset_flag_in,
	output tx_event_t tx_event_out
);
	logic req;
	// Never sends while the device holds responses back
	assign req = send_in && allow_in;
	assign tx_event_out = {req, req && supply_in, req && reset_flag_in};
endmodule
`default_nettype wire

/* File: supply_fault_map.svh */
// Addresses, reset values, protocol codes and timing figures of the supply fault status block
`ifndef SUPPLY_FAULT_MAP_SVH
`define SUPPLY_FAULT_MAP_SVH

// ----------------------------------------------------------------
// Register addresses and reset values
// ----------------------------------------------------------------
`define SUMMARY_STATUS_ADDR 8'h01
`define SUPPLY_STATUS_ADDR 8'h02
`define SUPPLY_STATUS_RESET 8'h00
`define READ_DATA_RESET 8'h00
`define TEST_FLAG_RESET 1'h0
`define RESET_FLAG_RESET 1'h1
`define INIT_FLAG_RESET 1'h1
`define SHADOW_FIRST_RESET 6'h00
`define SHADOW_THIRD_RESET 2'h0

// ----------------------------------------------------------------
// Protocol selection codes
// ----------------------------------------------------------------
`define PROTO_PSI5_A 3'h1
`define PROTO_PSI5_B 3'h5
`define PROTO_I2C_A 3'h6
`define PROTO_I2C_B 3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 10
`define TICK_PERIOD_NS 1000
`define RECOVERY_TIME_TICKS 16'h0064
`define DATA_VALID_DELAY_US 1000

`endif

/* File: supply_fault_pkg.sv */
// Types shared by the supply fault status block
package supply_fault_pkg;

	typedef struct packed
	{
		logic buffer_undervoltage_fault;
		logic bus_input_undervoltage_fault;
		logic buffer_overvoltage_fault;
		logic reserved;
		logic analog_regulator_fault;
		logic digital_regulator_fault;
		logic memory_regulator_fault;
		logic continuity_fault;
	} supply_fault_status_t;

	typedef struct packed
	{
		logic ch0_fault;
		logic ch1_fault;
		logic comm_fault;
		logic memtemp_fault;
		logic supply_fault;
		logic test_active_flag;
		logic reset_occurred_flag;
		logic init_in_progress_flag;
	} device_summary_status_t;

	typedef struct packed
	{
		logic request;
		logic reports_supply;
		logic reports_reset;
	} tx_event_t;

	typedef struct packed
	{
		logic valid;
		logic channel;
		logic is_third;
		logic [7:0] data;
	} cfg_write_t;

	typedef enum logic [1:0] {PROTO_DSI_SPI = 2'h0, PROTO_PSI5 = 2'h1, PROTO_I2C = 2'h2} proto_class_t;

	typedef enum logic [1:0] {RCV_IDLE = 2'h0, RCV_HOLD = 2'h1, RCV_COUNT = 2'h3, RCV_REPORT = 2'h2} recovery_state_t;

endpackage

/* File: supply_fault_props.sv */
// Port checks for the supply fault status block
`timescale 1ns/1ns
`default_nettype none
module supply_fault_props
	import supply_fault_pkg::*;
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [6:0] supply_monitor_in,
	input wire logic [2:0] protocol_select_in,
	input wire logic supply_autoclear_select_in,
	input wire logic reg_rd_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire tx_event_t tx_event_in,
	input wire logic [7:0] reg_rd_data_out,
	input wire logic tx_error_code_out,
	input wire logic supply_fault_out,
	input wire logic timer_zero_out,
	input wire device_summary_status_t device_summary_status_out,
	input wire supply_fault_status_t supply_fault_status_out
);
	logic take;
	logic autoclr;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (reset_in);
	assign take = reg_rd_en_in && clk_en_in;
	// PSI5 and the autoclear bit both clear without any host read
	assign autoclr = supply_autoclear_select_in || protocol_select_in == 3'h1 || protocol_select_in == 3'h5;
	// ------
	// Assertions
	// ------
	property p_sum_or;
		supply_fault_out == (supply_fault_status_out != 8'h00) && device_summary_status_out.supply_fault == supply_fault_out;
	endproperty
	a_sum_or: assert property (p_sum_or) else $error("supply summary differs from fault bits");
	property p_reload;
		(clk_en_in && supply_monitor_in != 7'h00) [*4] |-> !timer_zero_out;
	endproperty
	a_reload: assert property (p_reload) else $error("timer not reloaded by live fault");
	property p_hold;
		$fell(timer_zero_out) |=> !timer_zero_out [*4];
	endproperty
	a_hold: assert property (p_hold) else $error("timer expired too soon");
	property p_rd_supply;
		take && reg_addr_in == 8'h02 |=> reg_rd_data_out == $past(supply_fault_status_out);
	endproperty
	a_rd_supply: assert property (p_rd_supply) else $error("supply read data wrong");
	property p_rd_reset;
		take && reg_addr_in == 8'h01 |=> !device_summary_status_out.reset_occurred_flag;
	endproperty
	a_rd_reset: assert property (p_rd_reset) else $error("reset flag survived summary read");
	property p_err_once;
		tx_error_code_out && tx_event_in.request && clk_en_in |=> !tx_error_code_out;
	endproperty
	a_err_once: assert property (p_err_once) else $error("error code sent more than once");
	property p_clear_zero;
		$fell(supply_fault_out) |-> timer_zero_out;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("supply fault cleared with timer running");
	property p_auto;
		(autoclr && clk_en_in && supply_monitor_in == 7'h00) [*3] ##0 (supply_fault_out && timer_zero_out) |=> !supply_fault_out;
	endproperty
	a_auto: assert property (p_auto) else $error("supply fault not auto cleared");
	c_err: cover property (tx_error_code_out && tx_event_in.request);
	c_auto: cover property (autoclr && $fell(supply_fault_out));
	c_read: cover property (take && reg_addr_in == 8'h02 && supply_fault_out);
endmodule
`default_nettype wire

/* File: supply_fault_status_recovery.sv */
// Supply fault status, shared recovery timer and device summary flags
//
// Function
// - Summary supply bit is the OR of all seven supply fault bits.
// - Any supply fault present reloads the single shared recovery timer.
// - Without faults the timer counts down once per tick and stops at zero.
// - DSI3/SPI, autoclear off: silent while timer runs, then one error-code response.
// - DSI3/SPI, autoclear off: supply read or reporting transmission clears, only at zero.
// - PSI5: transmissions suppressed while timer runs; auto-clear at zero, then resume.
// - DSI3/SPI, autoclear on: suppressed while timer runs; auto-clear at zero.
// - I2C, autoclear off: no response until expiry; supply read then clears.
// - Test flag follows test mode; cleared only by test operation or power cycle.
// - Reset flag set by reset; cleared by summary read or reporting transmission.
// - Init flag set by reset or change of config first[7:2] or third[1:0].
// - Init flag clears after the data valid delay elapses.
// - Buffer undervoltage monitor sets its bit; cleared by supply policy.
// - Bus input undervoltage sets its bit and reloads the timer.
// - Buffer overvoltage monitor sets its bit; cleared by supply policy.
// - Analog regulator fault sets its bit and acts as supply fault.
// - Digital regulator fault sets its bit and acts as supply fault.
// - Continuity break sets its bit and reloads the timer.
// - Memory regulator fault sets its bit and joins the summary.
`include "supply_fault_map.svh"
`timescale 1ns/1ns
`default_nettype none

module supply_fault_status_recovery
	import supply_fault_pkg::*;
#(
	parameter logic [15:0] RECOVERY_TICKS = `RECOVERY_TIME_TICKS,
	parameter logic [9:0] TICK_CYCLES = 10'(`TICK_PERIOD_NS / `CLK_PERIOD_NS),
	parameter logic [23:0] DATA_VALID_CYCLES = 24'(`DATA_VALID_DELAY_US * 1000 / `CLK_PERIOD_NS)
)
(
	input wire logic mclk_in,
	input wire logic reset_in,
	input wire logic clk_en_in,
	input wire logic [6:0] supply_monitor_in,
	input wire logic [2:0] protocol_select_in,
	input wire logic supply_autoclear_select_in,
	input wire logic test_enter_in,
	input wire logic test_exit_in,
	input wire logic [3:0] other_faults_in,
	input wire logic reg_rd_en_in,
	input wire logic [7:0] reg_addr_in,
	input wire tx_event_t tx_event_in,
	input wire cfg_write_t cfg_write_in,
	output logic [7:0] reg_rd_data_out,
	output logic reg_rd_valid_out,
	output logic tx_allow_out,
	output logic tx_error_code_out,
	output logic supply_fault_out,
	output logic timer_zero_out,
	output device_summary_status_t device_summary_status_out,
	output supply_fault_status_t supply_fault_status_out
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic proto_class_t proto_class(input logic [2:0] sel);
		if (sel == `PROTO_PSI5_A || sel == `PROTO_PSI5_B)
			return PROTO_PSI5;
		else if (sel == `PROTO_I2C_A || sel == `PROTO_I2C_B)
			return PROTO_I2C;
		else
			return PROTO_DSI_SPI;
	endfunction

	function automatic logic is_read(input logic en, input logic [7:0] addr, input logic [7:0] target);
		return en && (addr == target);
	endfunction

	// ----------------------------------------------------------------
	// Monitor synchronisers
	// ----------------------------------------------------------------
	// Monitor levels are asynchronous; nothing but the second stage reads the first
	logic [6:0] mon_meta;
	logic [6:0] mon_sync;

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			mon_meta <= '0;
			mon_sync <= '0;
		end
		else if (clk_en_in)
		begin
			mon_meta <= supply_monitor_in;
			mon_sync <= mon_meta;
		end
	end

	// ----------------------------------------------------------------
	// Supply faults and recovery timer
	// ----------------------------------------------------------------
	supply_fault_status_t status;
	supply_fault_status_t next_status;
	supply_fault_status_t live;
	recovery_state_t rcv_state;
	recovery_state_t next_rcv_state;
	logic [15:0] timer;
	logic [15:0] next_timer;
	logic [9:0] prescale;
	logic [9:0] next_prescale;
	logic err_pending;
	logic next_err_pending;
	logic fault_live;
	logic tick;
	logic timer_zero;
	logic auto_clear;
	logic host_clear;
	logic do_clear;
	proto_class_t pclass;

	always_comb
	begin
		live = supply_fault_status_t'({mon_sync[6:4], 1'h0, mon_sync[3:0]});
		fault_live = |mon_sync;
		pclass = proto_class(protocol_select_in);
		// Prescaler free-runs, so the first count after a fault may come up to one tick early
		tick = (prescale == '0);
		timer_zero = (timer == '0);
		next_prescale = tick ? TICK_CYCLES - 10'h001 : prescale - 10'h001;

		// A live fault keeps the timer pinned at the reload value
		if (fault_live)
			next_timer = RECOVERY_TICKS;
		else if (tick && !timer_zero)
			next_timer = timer - 16'h0001;
		else
			next_timer = timer;

		// I2C with autoclear set follows the other autoclear modes
		auto_clear = (pclass == PROTO_PSI5) || supply_autoclear_select_in;
		// Host clears are ignored while the timer runs or a monitor still reports
		host_clear = is_read(reg_rd_en_in, reg_addr_in, `SUPPLY_STATUS_ADDR)
			|| (pclass == PROTO_DSI_SPI && tx_event_in.request && tx_event_in.reports_supply);
		do_clear = timer_zero && !fault_live && (auto_clear || host_clear);

		// Set wins over clear: a fault seen in the clearing cycle stays latched
		next_status = do_clear ? supply_fault_status_t'(`SUPPLY_STATUS_RESET) : status;
		next_status = next_status | live;

		next_rcv_state = rcv_state;
		case (rcv_state)
			RCV_IDLE:
				if (fault_live)
					next_rcv_state = RCV_HOLD;
			RCV_HOLD:
				if (!fault_live)
					next_rcv_state = RCV_COUNT;
			RCV_COUNT:
				if (fault_live)
					next_rcv_state = RCV_HOLD;
				else if (next_timer == '0)
					next_rcv_state = RCV_REPORT;
			RCV_REPORT:
				if (fault_live)
					next_rcv_state = RCV_HOLD;
				else if (next_status == supply_fault_status_t'(`SUPPLY_STATUS_RESET))
					next_rcv_state = RCV_IDLE;
			default:
				next_rcv_state = RCV_IDLE;
		endcase

		// In DSI3/SPI with autoclear off, one response carries the error code once the timer has expired
		next_err_pending = err_pending;
		if (fault_live)
			next_err_pending = 1'h0;
		else if (rcv_state == RCV_COUNT && next_rcv_state == RCV_REPORT)
			next_err_pending = (pclass == PROTO_DSI_SPI) && !supply_autoclear_select_in;
		else if (tx_event_in.request && timer_zero)
			next_err_pending = 1'h0;
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			status <= supply_fault_status_t'(`SUPPLY_STATUS_RESET);
			rcv_state <= RCV_IDLE;
			timer <= '0;
			prescale <= '0;
			err_pending <= 1'h0;
		end
		else if (clk_en_in)
		begin
			status <= next_status;
			rcv_state <= next_rcv_state;
			timer <= next_timer;
			prescale <= next_prescale;
			err_pending <= next_err_pending;
		end
	end

	// ----------------------------------------------------------------
	// Summary flags and configuration shadows
	// ----------------------------------------------------------------
	logic test_flag;
	logic next_test_flag;
	logic reset_flag;
	logic next_reset_flag;
	logic init_flag;
	logic next_init_flag;
	logic [23:0] init_count;
	logic [23:0] next_init_count;
	logic [5:0] shadow_first [2];
	logic [5:0] next_shadow_first [2];
	logic [1:0] shadow_third [2];
	logic [1:0] next_shadow_third [2];
	logic cfg_changed;

	// Shadows keep only the bits whose change restarts initialisation
	always_comb
	begin
		next_shadow_first = shadow_first;
		next_shadow_third = shadow_third;
		cfg_changed = 1'h0;
		if (cfg_write_in.valid)
		begin
			if (cfg_write_in.is_third)
			begin
				cfg_changed = cfg_write_in.data[1:0] != shadow_third[cfg_write_in.channel];
				next_shadow_third[cfg_write_in.channel] = cfg_write_in.data[1:0];
			end
			else
			begin
				cfg_changed = cfg_write_in.data[7:2] != shadow_first[cfg_write_in.channel];
				next_shadow_first[cfg_write_in.channel] = cfg_write_in.data[7:2];
			end
		end

		// Register reads never touch the test flag
		next_test_flag = test_flag;
		if (test_exit_in)
			next_test_flag = 1'h0;
		if (test_enter_in)
			next_test_flag = 1'h1;

		next_reset_flag = reset_flag;
		if (is_read(reg_rd_en_in, reg_addr_in, `SUMMARY_STATUS_ADDR)
			|| (tx_event_in.request && tx_event_in.reports_reset))
			next_reset_flag = 1'h0;

		// Filters with slow step response may still be settling when this clears
		next_init_flag = init_flag;
		next_init_count = init_count;
		if (cfg_changed)
		begin
			next_init_flag = 1'h1;
			next_init_count = DATA_VALID_CYCLES;
		end
		else if (init_flag)
		begin
			if (init_count == '0)
				next_init_flag = 1'h0;
			else
				next_init_count = init_count - 24'h00_0001;
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			test_flag <= `TEST_FLAG_RESET;
			reset_flag <= `RESET_FLAG_RESET;
			init_flag <= `INIT_FLAG_RESET;
			init_count <= DATA_VALID_CYCLES;
			shadow_first <= '{`SHADOW_FIRST_RESET, `SHADOW_FIRST_RESET};
			shadow_third <= '{`SHADOW_THIRD_RESET, `SHADOW_THIRD_RESET};
		end
		else if (clk_en_in)
		begin
			test_flag <= next_test_flag;
			reset_flag <= next_reset_flag;
			init_flag <= next_init_flag;
			init_count <= next_init_count;
			shadow_first <= next_shadow_first;
			shadow_third <= next_shadow_third;
		end
	end

	// ----------------------------------------------------------------
	// Read port and registered outputs
	// ----------------------------------------------------------------
	device_summary_status_t summary_now;
	device_summary_status_t next_summary;
	logic [7:0] next_rd_data;
	logic next_rd_valid;

	always_comb
	begin
		// Upper summary bits come from blocks outside this one and pass straight through
		summary_now = {other_faults_in, |status, test_flag, reset_flag, init_flag};
		next_summary = {other_faults_in, |next_status, next_test_flag, next_reset_flag, next_init_flag};
		next_rd_valid = reg_rd_en_in;
		next_rd_data = reg_rd_data_out;
		// Reads return the value before any clear that the read itself causes
		if (reg_rd_en_in)
		begin
			case (reg_addr_in)
				`SUMMARY_STATUS_ADDR:
					next_rd_data = summary_now;
				`SUPPLY_STATUS_ADDR:
					next_rd_data = status;
				// Unmapped addresses read zero rather than flag an error
				default:
					next_rd_data = `READ_DATA_RESET;
			endcase
		end
	end

	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			reg_rd_data_out <= `READ_DATA_RESET;
			reg_rd_valid_out <= 1'h0;
			tx_allow_out <= 1'h1;
			tx_error_code_out <= 1'h0;
			supply_fault_out <= 1'h0;
			timer_zero_out <= 1'h1;
			device_summary_status_out <= {4'h0, 1'h0, `TEST_FLAG_RESET, `RESET_FLAG_RESET, `INIT_FLAG_RESET};
			supply_fault_status_out <= supply_fault_status_t'(`SUPPLY_STATUS_RESET);
		end
		else if (clk_en_in)
		begin
			reg_rd_data_out <= next_rd_data;
			reg_rd_valid_out <= next_rd_valid;
			tx_allow_out <= (next_timer == '0);
			tx_error_code_out <= next_err_pending;
			supply_fault_out <= |next_status;
			timer_zero_out <= (next_timer == '0);
			device_summary_status_out <= next_summary;
			supply_fault_status_out <= next_status;
		end
	end

endmodule
`default_nettype wire

/* File: supply_fault_status_recovery_tb_top.sv */
// Self-checking bench for the supply fault status block
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("Error %0t: %h not %h", $time, a, b); end end
module supply_fault_status_recovery_tb_top
	import supply_fault_pkg::*;
;
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [6:0] supply_monitor_in = 7'h00;
	logic [2:0] protocol_select_in = 3'h0;
	logic supply_autoclear_select_in = 1'b0;
	logic test_enter_in = 1'b0;
	logic test_exit_in = 1'b0;
	logic reg_rd_en_in = 1'b0;
	logic [7:0] reg_addr_in = 8'h00;
	logic send = 1'b0;
	cfg_write_t cfg_write_in = '0;
	tx_event_t tx_event_in;
	logic [7:0] reg_rd_data_out;
	logic reg_rd_valid_out, tx_allow_out, tx_error_code_out, supply_fault_out, timer_zero_out;
	device_summary_status_t device_summary_status_out;
	supply_fault_status_t supply_fault_status_out;
	logic [2:0] dsi_code [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
	logic [2:0] mode_code [6] = '{3'h1, 3'h5, 3'h6, 3'h7, 3'h2, 3'h6};
	logic [0:5] mode_ac = 6'h03;
	int n_fail = 0;
	int num_checks = 0;
	// Short counts keep the run brief; expectations follow these values
	supply_fault_status_recovery #(.RECOVERY_TICKS(16'h0003), .TICK_CYCLES(10'h002), .DATA_VALID_CYCLES(24'h00_0005))
		i_supply_fault_status_recovery (.*, .clk_en_in(1'b1), .other_faults_in(4'h5));
	response_host i_response_host (.send_in(send), .allow_in(tx_allow_out), .supply_in(supply_fault_out),
		.reset_flag_in(device_summary_status_out.reset_occurred_flag), .tx_event_out(tx_event_in));
	initial forever #5 mclk_in = ~mclk_in;
	// ------
	// Bus tasks
	// ------
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		@(posedge mclk_in);
		reg_rd_en_in <= 1'b1;
		reg_addr_in <= addr;
		@(posedge mclk_in);
		reg_rd_en_in <= 1'b0;
		@(negedge mclk_in);
		`CHK(reg_rd_valid_out, 1'b1)
		`CHK(reg_rd_data_out, exp)
	endtask
	task automatic respond();
		@(posedge mclk_in);
		send <= 1'b1;
		@(posedge mclk_in);
		send <= 1'b0;
		@(negedge mclk_in);
	endtask
	task automatic cfg(input logic third, input logic [7:0] data, input logic exp);
		@(posedge mclk_in);
		cfg_write_in <= '{1'b1, 1'b0, third, data};
		@(posedge mclk_in);
		cfg_write_in.valid <= 1'b0;
		@(negedge mclk_in);
		`CHK(device_summary_status_out.init_in_progress_flag, exp)
		repeat (10) @(posedge mclk_in);
	endtask
	task automatic fault(input logic [6:0] pins, input logic [7:0] exp, input logic [2:0] proto, input logic ac);
		int k;
		@(posedge mclk_in);
		supply_monitor_in <= pins;
		protocol_select_in <= proto;
		supply_autoclear_select_in <= ac;
		repeat (5) @(posedge mclk_in);
		supply_monitor_in <= 7'h00;
		@(negedge mclk_in);
		`CHK(tx_allow_out, 1'b0)
		rd(8'h02, exp);
		`CHK(supply_fault_status_out, exp)
		for (k = 0; k < 40 && timer_zero_out !== 1'b1; k++)
			@(negedge mclk_in);
		if (k == 40)
			n_fail++;
		`CHK(timer_zero_out, 1'b1)
		`CHK(tx_allow_out, 1'b1)
	endtask
	// ------
	// Scenarios
	// ------
	initial
	begin
		logic [7:0] exp;
		logic auto_mode;
		repeat (12) @(posedge mclk_in);
		reset_in <= 1'b0;
		rd(8'h01, 8'h53);
		repeat (20) @(posedge mclk_in);
		rd(8'h01, 8'h50);
		rd(8'h05, 8'h00);
		@(posedge mclk_in);
		test_enter_in <= 1'b1;
		@(posedge mclk_in);
		test_enter_in <= 1'b0;
		rd(8'h01, 8'h54);
		rd(8'h01, 8'h54);
		@(posedge mclk_in);
		test_exit_in <= 1'b1;
		@(posedge mclk_in);
		test_exit_in <= 1'b0;
		rd(8'h01, 8'h50);
		cfg(1'b0, 8'h04, 1'b1);
		cfg(1'b0, 8'h07, 1'b0);
		cfg(1'b1, 8'h02, 1'b1);
		rd(8'h01, 8'h50);
		for (int i = 0; i < 7; i++)
		begin
			exp = (i > 3) ? 8'(2 << i) : 8'(1 << i);
			fault(7'(1 << i), exp, dsi_code[i % 4], 1'b0);
			`CHK(tx_error_code_out, 1'b1)
			`CHK(supply_fault_out, 1'b1)
			if (i % 2 == 1)
			begin
				respond();
				`CHK(tx_error_code_out, 1'b0)
				`CHK(supply_fault_out, 1'b0)
			end
			else
			begin
				rd(8'h02, exp);
				rd(8'h02, 8'h00);
			end
		end
		for (int i = 0; i < 6; i++)
		begin
			auto_mode = mode_ac[i] || mode_code[i] == 3'h1 || mode_code[i] == 3'h5;
			fault(7'h01, 8'h01, mode_code[i], mode_ac[i]);
			repeat (3) @(negedge mclk_in);
			`CHK(supply_fault_out, !auto_mode)
			`CHK(tx_error_code_out, 1'b0)
			if (!auto_mode)
			begin
				respond();
				`CHK(supply_fault_out, 1'b1)
				rd(8'h02, 8'h01);
				`CHK(supply_fault_out, 1'b0)
			end
		end
		@(posedge mclk_in);
		reset_in <= 1'b1;
		repeat (2) @(posedge mclk_in);
		reset_in <= 1'b0;
		rd(8'h01, 8'h53);
		stop_test();
	end
endmodule
bind supply_fault_status_recovery supply_fault_props i_supply_fault_props (.*);
`default_nettype wire
